/* File: hw/pau_auth_unit.sv */
/*
 * Packet authentication unit: keyed tag insertion on transmit, tag check
 * and header strip on receive, register file on AXI4-Lite.
 * Assumes keys, freshness and packets come from logic on aclk.
 */
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pau_consts.svh"

// What this block does
// - transmit: tag header ahead, pass down
// - receive: verify tag, strip header, forward up
// - terminal transmit keys from reverse link key
// - terminal receive keys from forward link key
// - network transmit keys from forward link key
// - network receive keys from reverse link key
// - long key trimmed to low key bits
// - short key drops the packet
// - message is payload then 96-bit freshness
// - HMAC-SHA256, tag is digest low bits
// - tag mismatch raises failure, drops packet
// - header tag present by flag or setting
// - no trailer is ever appended
// - reset loads default configuration
// - tag length is 96 bits
// - key length is 160 bits
// - setting zero needs flag, one all secure
module pau_auth_unit #(
	parameter int MAX_WORDS = 64
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// register bus
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	// link keys from key exchange
	input  wire logic [255:0] forward_link_key,
	input  wire logic [8:0]   forward_link_key_len,
	input  wire logic         forward_link_key_ok,
	input  wire logic [255:0] reverse_link_key,
	input  wire logic [8:0]   reverse_link_key_len,
	input  wire logic         reverse_link_key_ok,
	// incoming packets, sideband sampled on the first beat
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [31:0]  in_data,
	input  wire logic         in_last,
	input  wire logic         in_dir_rx,
	input  wire logic         in_secure_packet_flag,
	input  wire logic         in_terminal_id_present_flag,
	input  wire logic [95:0]  in_freshness_value,
	// toward the security sublayer
	output logic              down_valid,
	input  wire logic         down_ready,
	output logic [31:0]       down_data,
	output logic              down_last,
	// toward the encryption layer
	output logic              up_valid,
	input  wire logic         up_ready,
	output logic [31:0]       up_data,
	output logic              up_last,
	// indications
	output logic              auth_fail_indication,
	output logic              irq
);
	localparam int AW = $clog2(MAX_WORDS);

	// refused at elaboration: the word counters and block index cannot serve other depths
	if (MAX_WORDS < 4 || MAX_WORDS > 4096) begin : g_depth_check
		$error("MAX_WORDS must lie in 4..4096");
	end

	pau_pkg::pau_state_t state;
	pau_pkg::pau_phase_t phase;
	logic [31:0]  mem [MAX_WORDS];
	logic [31:0]  ctrl, fail_cnt, cur_word, send_word, rd_word, msg_bits;
	logic [2:0]   irq_stat, irq_mask, ev;
	logic [15:0]  n_words, send_idx, blk_idx, hdr_cnt, pos, msg_total, out_total;
	logic [3:0]   fill_cnt;
	logic         first_beat, dir_rx, auth, auth_now, dir_now, ovf, mem_we;
	logic         use_fwd, key_good, sha_start, sha_first, sha_done, hdr_out;
	logic         wr_en, rd_en, o_ready;
	logic [95:0]  fresh, rx_mac, mac;
	logic [159:0] key_sel;
	logic [255:0] inner_dig, sha_digest, sel_key;
	logic [8:0]   sel_len;
	logic [511:0] blk;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
					      input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8 * i +: 8] = nw[8 * i +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [31:0] word_of(input logic [95:0] x, input logic [15:0] j);
		return x[95 - 32 * int'(j[1:0]) -: 32];
	endfunction : word_of

	assign wr_en = s_axi_awready;
	assign rd_en = s_axi_arready;

	// register bus: write and read each answer one cycle after acceptance
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PAU_RESP_OK;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `PAU_RESP_OK;
			s_axi_rdata   <= 32'h0;
		end else begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (wr_en) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (s_axi_awaddr == `PAU_OFF_CTRL || s_axi_awaddr == `PAU_OFF_IRQ_STAT
						|| s_axi_awaddr == `PAU_OFF_IRQ_MASK) ? `PAU_RESP_OK : `PAU_RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_en) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= (s_axi_araddr <= `PAU_OFF_FAIL_CNT && s_axi_araddr[1:0] == 2'h0)
						? `PAU_RESP_OK : `PAU_RESP_ERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		unique case (s_axi_araddr)
			`PAU_OFF_CTRL:     rd_word = ctrl;
			`PAU_OFF_STATUS:   rd_word = {29'h0, ovf, auth, state != pau_pkg::ST_RECV};
			`PAU_OFF_IRQ_STAT: rd_word = {29'h0, irq_stat};
			`PAU_OFF_IRQ_MASK: rd_word = {29'h0, irq_mask};
			`PAU_OFF_FAIL_CNT: rd_word = fail_cnt;
			default:           rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl     <= `PAU_CTRL_RST;
			irq_mask <= `PAU_MASK_RST;
		end else if (wr_en && s_axi_awaddr == `PAU_OFF_CTRL) begin
			ctrl <= merge(ctrl, s_axi_wdata, s_axi_wstrb) & `PAU_CTRL_MASK;
		end else if (wr_en && s_axi_awaddr == `PAU_OFF_IRQ_MASK && s_axi_wstrb[0]) begin
			irq_mask <= s_axi_wdata[2:0];
		end
	end

	// sticky events: a new event wins over a write-one-to-clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat <= 3'h0;
			irq      <= 1'b0;
			fail_cnt <= 32'h0;
		end else begin
			if (wr_en && s_axi_awaddr == `PAU_OFF_IRQ_STAT && s_axi_wstrb[0]) begin
				irq_stat <= (irq_stat & ~s_axi_wdata[2:0]) | ev;
			end else begin
				irq_stat <= irq_stat | ev;
			end
			irq <= |(irq_stat & irq_mask);
			if (ev[`PAU_IRQ_FAIL]) begin
				fail_cnt <= fail_cnt + 32'h1;
			end
		end
	end

	// header present by flag or setting; only setting one widens it
	assign auth_now = first_beat ? in_secure_packet_flag && (in_terminal_id_present_flag
			|| ctrl[`PAU_CTRL_MODE_LO +: 8] == `PAU_MODE_ALL) : auth;
	assign dir_now  = first_beat ? in_dir_rx : dir_rx;
	assign mem_we   = state == pau_pkg::ST_RECV && in_valid && in_ready
			&& !(dir_now && auth_now && hdr_cnt < 16'(`PAU_MAC_WORDS))
			&& n_words < 16'(MAX_WORDS);

	// terminal and network pick opposite link keys per direction
	assign use_fwd  = ctrl[`PAU_CTRL_TERM] == dir_rx;
	assign sel_key  = use_fwd ? forward_link_key : reverse_link_key;
	assign sel_len  = use_fwd ? forward_link_key_len : reverse_link_key_len;
	// key must reach the key length
	assign key_good = (use_fwd ? forward_link_key_ok : reverse_link_key_ok)
			&& sel_len >= 9'(`PAU_KEY_BITS);

	// message words: payload, freshness, then hash padding
	assign pos       = {blk_idx[11:0], fill_cnt};
	assign msg_total = 16'((n_words + 16'd21) >> 4) << 4;
	assign msg_bits  = 32'({n_words + 16'(`PAU_MAC_WORDS), 5'h00}) + `PAU_INNER_BASE;
	always_comb begin
		cur_word = 32'h0;
		unique case (phase)
			pau_pkg::PH_IKEY, pau_pkg::PH_OKEY: begin
				cur_word = (phase == pau_pkg::PH_IKEY) ? `PAU_IPAD : `PAU_OPAD;
				if (fill_cnt < 4'(`PAU_KEY_WORDS)) begin
					cur_word = cur_word ^ key_sel[159 - 32 * int'(fill_cnt) -: 32];
				end
			end
			pau_pkg::PH_MSG: begin
				if (pos < n_words) begin
					cur_word = mem[pos[AW-1:0]];
				end else if (pos < n_words + 16'(`PAU_MAC_WORDS)) begin
					cur_word = word_of(fresh, pos - n_words);
				end else if (pos == n_words + 16'(`PAU_MAC_WORDS)) begin
					cur_word = `PAU_PAD_ONE;
				end else if (pos == msg_total - 16'd1) begin
					cur_word = msg_bits;
				end
			end
			pau_pkg::PH_OUT: begin
				if (fill_cnt < 4'h8) begin
					cur_word = inner_dig[255 - 32 * int'(fill_cnt) -: 32];
				end else if (fill_cnt == 4'h8) begin
					cur_word = `PAU_PAD_ONE;
				end else if (fill_cnt == 4'hf) begin
					cur_word = `PAU_OUTER_LEN;
				end
			end
		endcase
	end

	// transmit output leads with the tag; nothing follows the payload
	assign hdr_out   = !dir_rx && auth;
	assign out_total = n_words + (hdr_out ? 16'(`PAU_MAC_WORDS) : 16'h0);
	assign send_word = (hdr_out && send_idx < 16'(`PAU_MAC_WORDS)) ? word_of(mac, send_idx)
			: mem[AW'(send_idx - (hdr_out ? 16'(`PAU_MAC_WORDS) : 16'h0))];
	assign o_ready   = dir_rx ? (!up_valid || up_ready) : (!down_valid || down_ready);

	always_ff @(posedge aclk) begin
		if (mem_we) begin
			mem[n_words[AW-1:0]] <= in_data;
		end
	end

	pau_sha256_core u_sha (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (sha_start),
		.first   (sha_first),
		.block   (blk),
		.done    (sha_done),
		.digest  (sha_digest)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= pau_pkg::ST_IDLE;
			phase <= pau_pkg::PH_IKEY;
			{in_ready, first_beat, dir_rx, auth, ovf, sha_start, sha_first} <= 7'h00;
			{down_valid, down_last, up_valid, up_last, auth_fail_indication} <= 5'h00;
			{n_words, send_idx, blk_idx, hdr_cnt} <= 64'h0;
			{fill_cnt, ev} <= 7'h00;
			{fresh, rx_mac, mac} <= 288'h0;
			{key_sel, inner_dig} <= 416'h0;
			blk       <= 512'h0;
			down_data <= 32'h0;
		end else begin
			sha_start            <= 1'b0;
			auth_fail_indication <= 1'b0;
			ev                   <= 3'h0;
			unique case (state)
				pau_pkg::ST_IDLE: begin
					{n_words, send_idx, blk_idx, hdr_cnt} <= 64'h0;
					{first_beat, ovf, in_ready} <= 3'h5;
					state <= pau_pkg::ST_RECV;
				end
				// whole packet held before any tag work
				pau_pkg::ST_RECV: if (in_valid && in_ready) begin
					first_beat <= 1'b0;
					if (first_beat) begin
						dir_rx <= in_dir_rx;
						auth   <= auth_now;
						// freshness taken from the supplying party
						fresh  <= in_freshness_value;
					end
					if (dir_now && auth_now && hdr_cnt < 16'(`PAU_MAC_WORDS)) begin
						rx_mac  <= {rx_mac[63:0], in_data};
						hdr_cnt <= hdr_cnt + 16'h1;
					end else if (mem_we) begin
						n_words <= n_words + 16'h1;
					end else begin
						ovf <= 1'b1;
					end
					if (in_last) begin
						in_ready <= 1'b0;
						if (ovf || (!mem_we && !(dir_now && auth_now
								&& hdr_cnt < 16'(`PAU_MAC_WORDS)))
								|| (dir_now && auth_now && hdr_cnt < 16'h2)) begin
							ev[`PAU_IRQ_DROP] <= 1'b1;
							state <= pau_pkg::ST_IDLE;
						end else begin
							state <= auth_now ? pau_pkg::ST_KEY : pau_pkg::ST_SEND;
						end
					end
				end
				pau_pkg::ST_KEY: begin
					if (key_good) begin
						// longer keys keep their low bits
						key_sel <= sel_key[159:0];
						phase   <= pau_pkg::PH_IKEY;
						state   <= pau_pkg::ST_FILL;
					end else begin
						ev[`PAU_IRQ_DROP] <= 1'b1;
						state <= pau_pkg::ST_IDLE;
					end
				end
				pau_pkg::ST_FILL: begin
					blk      <= {blk[479:0], cur_word};
					fill_cnt <= fill_cnt + 4'h1;
					if (fill_cnt == 4'hf) begin
						sha_start <= 1'b1;
						sha_first <= phase == pau_pkg::PH_IKEY || phase == pau_pkg::PH_OKEY;
						state     <= pau_pkg::ST_HASH;
					end
				end
				pau_pkg::ST_HASH: if (sha_done) begin
					state <= pau_pkg::ST_FILL;
					unique case (phase)
						pau_pkg::PH_IKEY: phase <= pau_pkg::PH_MSG;
						pau_pkg::PH_MSG: begin
							if ({blk_idx[11:0] + 12'h1, 4'h0} == msg_total) begin
								inner_dig <= sha_digest;
								phase     <= pau_pkg::PH_OKEY;
							end else begin
								blk_idx <= blk_idx + 16'h1;
							end
						end
						pau_pkg::PH_OKEY: phase <= pau_pkg::PH_OUT;
						pau_pkg::PH_OUT: begin
							// tag is the low 96 digest bits
							mac   <= sha_digest[`PAU_MAC_BITS-1:0];
							state <= pau_pkg::ST_CHECK;
						end
					endcase
				end
				pau_pkg::ST_CHECK: begin
					if (dir_rx && mac != rx_mac) begin
						auth_fail_indication <= 1'b1;
						ev[`PAU_IRQ_FAIL]    <= 1'b1;
						state <= pau_pkg::ST_IDLE;
					end else begin
						state <= pau_pkg::ST_SEND;
					end
				end
				// receive forwards payload only, header stripped
				pau_pkg::ST_SEND: if (o_ready) begin
					if (send_idx < out_total) begin
						down_valid <= !dir_rx;
						up_valid   <= dir_rx;
						down_data  <= send_word;
						down_last  <= !dir_rx && send_idx == out_total - 16'h1;
						up_last    <= dir_rx && send_idx == out_total - 16'h1;
						send_idx   <= send_idx + 16'h1;
					end else begin
						{down_valid, up_valid} <= 2'h0;
						ev[`PAU_IRQ_DONE] <= 1'b1;
						state <= pau_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	assign up_data = down_data;

	// failure is visible as a sticky status bit
	a_fail_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		auth_fail_indication |=> irq_stat[`PAU_IRQ_FAIL]) else $error("fail not latched");
	// a failed packet does not go up in the three cycles after its check
	a_fail_no_fwd: assert property (@(posedge aclk) disable iff (!aresetn)
		state == pau_pkg::ST_CHECK && dir_rx && mac != rx_mac |=> !up_valid [*3])
		else $error("failed packet forwarded");
	a_short_key: assert property (@(posedge aclk) disable iff (!aresetn)
		state == pau_pkg::ST_KEY && sel_len < 9'(`PAU_KEY_BITS)
		|=> state == pau_pkg::ST_IDLE ##1 irq_stat[`PAU_IRQ_DROP]) else $error("short key used");
	a_key_trim: assert property (@(posedge aclk) disable iff (!aresetn)
		state == pau_pkg::ST_KEY && key_good |=> key_sel == $past(sel_key[159:0]))
		else $error("key not trimmed");
	a_term_tx_key: assert property (@(posedge aclk) disable iff (!aresetn)
		state == pau_pkg::ST_KEY && ctrl[`PAU_CTRL_TERM] && !dir_rx && !reverse_link_key_ok
		|=> state == pau_pkg::ST_IDLE) else $error("missing reverse key ignored");
	a_hold_hash: assert property (@(posedge aclk) disable iff (!aresetn)
		state == pau_pkg::ST_HASH |-> !down_valid && !up_valid) else $error("output during hash");
	a_out_stable: assert property (@(posedge aclk) disable iff (!aresetn)
		down_valid && !down_ready |=> down_valid && $stable(down_data))
		else $error("down word dropped");
	// transmit header leads with the tag
	a_tx_header: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(down_valid) && hdr_out |-> down_data == mac[95:64]) else $error("tag not first");
	// digest completes within the round budget
	a_hash_bound: assert property (@(posedge aclk) disable iff (!aresetn)
		sha_start |-> ##[1:70] sha_done) else $error("hash stalled");

endmodule : pau_auth_unit

`default_nettype wire

/* File: hw/pau_consts.svh */
/*
 * Offsets, field positions, reset values and fixed sizes of the packet
 * authentication unit. Assumes inclusion by bare name from hw/ sources.
 */
`ifndef PAU_CONSTS_SVH
`define PAU_CONSTS_SVH

`define PAU_MAC_BITS     96
`define PAU_KEY_BITS     160
`define PAU_MAC_WORDS    3
`define PAU_KEY_WORDS    5
`define PAU_IPAD         32'h36363636
`define PAU_OPAD         32'h5c5c5c5c
`define PAU_PAD_ONE      32'h80000000
`define PAU_OUTER_LEN    32'h00000300
`define PAU_INNER_BASE   32'h00000200
`define PAU_MODE_ALL     8'h01

`define PAU_OFF_CTRL     8'h00
`define PAU_OFF_STATUS   8'h04
`define PAU_OFF_IRQ_STAT 8'h08
`define PAU_OFF_IRQ_MASK 8'h0c
`define PAU_OFF_FAIL_CNT 8'h10

`define PAU_CTRL_TERM    0
`define PAU_CTRL_MODE_LO 8
`define PAU_CTRL_MASK    32'h0000ff01
`define PAU_CTRL_RST     32'h00000000
`define PAU_MASK_RST     3'h0
`define PAU_IRQ_FAIL     0
`define PAU_IRQ_DROP     1
`define PAU_IRQ_DONE     2

`define PAU_RESP_OK      2'h0
`define PAU_RESP_ERR     2'h2

`endif

/* File: hw/pau_pkg.sv */
/*
 * Types shared by the packet authentication unit.
 * Assumes nothing of its surroundings.
 */
package pau_pkg;

	typedef enum logic [2:0] {
		ST_IDLE, ST_RECV, ST_KEY, ST_FILL, ST_HASH, ST_CHECK, ST_SEND
	} pau_state_t;

	typedef enum logic [1:0] {
		PH_IKEY, PH_MSG, PH_OKEY, PH_OUT
	} pau_phase_t;

endpackage : pau_pkg

/* File: hw/pau_sha256_core.sv */
/*
 * One 512-bit block of SHA-256 compression, one round a cycle.
 * Assumes block is stable on start and start is a single-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module pau_sha256_core (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// block request
	input  wire logic         start,
	input  wire logic         first,
	input  wire logic [511:0] block,
	// result
	output logic              done,
	output logic [255:0]      digest
);
	localparam logic [255:0] IV =
		256'h6a09e667_bb67ae85_3c6ef372_a54ff53a_510e527f_9b05688c_1f83d9ab_5be0cd19;
	localparam logic [2047:0] KTAB = {
		256'h428a2f98_71374491_b5c0fbcf_e9b5dba5_3956c25b_59f111f1_923f82a4_ab1c5ed5,
		256'hd807aa98_12835b01_243185be_550c7dc3_72be5d74_80deb1fe_9bdc06a7_c19bf174,
		256'he49b69c1_efbe4786_0fc19dc6_240ca1cc_2de92c6f_4a7484aa_5cb0a9dc_76f988da,
		256'h983e5152_a831c66d_b00327c8_bf597fc7_c6e00bf3_d5a79147_06ca6351_14292967,
		256'h27b70a85_2e1b2138_4d2c6dfc_53380d13_650a7354_766a0abb_81c2c92e_92722c85,
		256'ha2bfe8a1_a81a664b_c24b8b70_c76c51a3_d192e819_d6990624_f40e3585_106aa070,
		256'h19a4c116_1e376c08_2748774c_34b0bcb5_391c0cb3_4ed8aa4a_5b9cca4f_682e6ff3,
		256'h748f82ee_78a5636f_84c87814_8cc70208_90befffa_a4506ceb_bef9a3f7_c67178f2};

	logic [255:0] v;
	logic [511:0] w;
	logic [6:0]   rnd;
	logic         busy;
	logic [31:0]  a, b, c, d, e, f, g, h, k, t1, t2, w16;
	logic [255:0] sum;

	function automatic logic [31:0] ror(input logic [31:0] x, input int n);
		return (x >> n) | (x << (32 - n));
	endfunction : ror

	always_comb begin
		{a, b, c, d, e, f, g, h} = v;
		k = KTAB[2047 - 32 * int'(rnd[5:0]) -: 32];
		t1 = h + (ror(e, 6) ^ ror(e, 11) ^ ror(e, 25)) + ((e & f) ^ (~e & g)) + k + w[511:480];
		t2 = (ror(a, 2) ^ ror(a, 13) ^ ror(a, 22)) + ((a & b) ^ (a & c) ^ (b & c));
		w16 = (ror(w[63:32], 17) ^ ror(w[63:32], 19) ^ (w[63:32] >> 10)) + w[223:192]
			+ (ror(w[479:448], 7) ^ ror(w[479:448], 18) ^ (w[479:448] >> 3)) + w[511:480];
		for (int i = 0; i < 8; i++) begin
			sum[32 * i +: 32] = digest[32 * i +: 32] + v[32 * i +: 32];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy   <= 1'b0;
			done   <= 1'b0;
			rnd    <= 7'h00;
			v      <= 256'h0;
			w      <= 512'h0;
			digest <= 256'h0;
		end else begin
			done <= 1'b0;
			if (start) begin
				// a fresh chain starts from the initial value, otherwise it continues
				v      <= first ? IV : digest;
				digest <= first ? IV : digest;
				w      <= block;
				rnd    <= 7'h00;
				busy   <= 1'b1;
			end else if (busy) begin
				if (rnd == 7'h40) begin
					digest <= sum;
					busy   <= 1'b0;
					done   <= 1'b1;
				end else begin
					v   <= {t1 + t2, a, b, c, d + t1, e, f, g};
					w   <= {w[479:0], w16};
					rnd <= rnd + 7'h01;
				end
			end
		end
	end

endmodule : pau_sha256_core

`default_nettype wire

/* File: bench/pau_stream_sink.sv */
/*
 * stream sink standing in for a neighbouring layer: takes words with
 * random stalls and keeps them for the bench. assumes sender on aclk.
 */
`timescale 1ns/1ps
`default_nettype none

module pau_stream_sink (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// stream
	input  wire logic        valid,
	output logic             ready,
	input  wire logic [31:0] data,
	input  wire logic        last,
	// bench control
	input  wire logic        clr
);
	logic [31:0] mem [0:7];
	logic [7:0]  lf;
	int          n;
	int          lw;

	always_ff @(posedge aclk) begin
		if (!aresetn || clr) begin
			n <= 0;
			lw <= -1;
		end else if (valid && ready) begin
			mem[n[2:0]] <= data;
			n <= n + 1;
			if (last) lw <= n;
		end
	end

	// stalls at random so the sender must really hold its word
	always_ff @(posedge aclk) begin
		lf <= aresetn ? {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]} : 8'h5a;
		ready <= aresetn && lf[0];
	end
endmodule : pau_stream_sink

`default_nettype wire

/* File: bench/pau_auth_unit_bench.sv */
/*
 * bench of the packet authentication unit: random keys and payloads,
 * tags looped back from transmit to receive. assumes two sink models.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((e) !== (s)) begin n_errors++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, s); end end

module pau_auth_unit_bench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata, in_data, down_data, up_data, sd, d;
	logic [3:0]   s_axi_wstrb;
	logic [1:0]   s_axi_bresp, s_axi_rresp, r;
	logic [255:0] forward_link_key, reverse_link_key;
	logic [8:0]   forward_link_key_len, reverse_link_key_len;
	logic forward_link_key_ok, reverse_link_key_ok, in_valid, in_ready, in_last, in_dir_rx;
	logic in_secure_packet_flag, in_terminal_id_present_flag, down_valid, down_ready, down_last;
	logic up_valid, up_ready, up_last, auth_fail_indication, irq, clr;
	logic [95:0]  in_freshness_value;
	logic [31:0]  pk [0:7];
	int           checks, n_errors, fails;

	pau_auth_unit #(.MAX_WORDS(8)) pau_auth_unit_inst (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .forward_link_key,
		.forward_link_key_len, .forward_link_key_ok, .reverse_link_key, .reverse_link_key_len,
		.reverse_link_key_ok, .in_valid, .in_ready, .in_data, .in_last, .in_dir_rx,
		.in_secure_packet_flag, .in_terminal_id_present_flag, .in_freshness_value, .down_valid,
		.down_ready, .down_data, .down_last, .up_valid, .up_ready, .up_data, .up_last,
		.auth_fail_indication, .irq);
	pau_stream_sink pau_stream_sink_inst (.aclk, .aresetn, .clr, .valid(down_valid),
		.ready(down_ready), .data(down_data), .last(down_last));
	pau_stream_sink pau_stream_sink_up_inst (.aclk, .aresetn, .clr, .valid(up_valid),
		.ready(up_ready), .data(up_data), .last(up_last));

	initial begin
		aclk = 0;
		forever #25 aclk = ~aclk;
	end

	always @(posedge aclk) if (auth_fail_indication === 1'b1) fails++;

	function automatic logic [31:0] rnd();
		sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
		return sd;
	endfunction : rnd

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do @(posedge aclk); while (!s_axi_awready);
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge aclk);
	endtask : rd

	// one packet of n words from pk[f], then wait until the unit is free again
	task automatic pkt(input logic rx, input logic tid, input int f, input int n);
		clr <= 1;
		@(posedge aclk);
		clr <= 0;
		in_dir_rx <= rx;
		in_terminal_id_present_flag <= tid;
		for (int i = 0; i < n; i++) begin
			in_valid <= 1;
			in_data <= pk[f + i];
			in_last <= (i == n - 1);
			do @(posedge aclk); while (!in_ready);
		end
		in_valid <= 0;
		repeat (3) @(posedge aclk);
		while (!in_ready) @(posedge aclk);
	endtask : pkt

	task automatic close_out();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	initial begin
		repeat (40000) @(posedge aclk);
		n_errors++;
		close_out();
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, in_valid} = '0;
		{in_last, in_dir_rx, in_secure_packet_flag, in_terminal_id_present_flag, clr} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, in_data} = '0;
		s_axi_wstrb = 4'hf;
		aresetn = 0;
		sd = 32'h7ee8;
		for (int i = 0; i < 8; i++) begin
			forward_link_key[i*32 +: 32] = rnd();
			reverse_link_key[i*32 +: 32] = rnd();
			pk[i] = rnd();
		end
		in_freshness_value = {rnd(), rnd(), rnd()};
		{forward_link_key_ok, reverse_link_key_ok} = 2'h3;
		forward_link_key_len = 9'd160;
		reverse_link_key_len = 9'd200;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(8'h00); `CHK("ctrl", 32'h0, d)
		rd(8'h0c); `CHK("mask", 32'h0, d)
		rd(8'h20); `CHK("unmapped", 2'h2, r)
		wr(8'h04, 32'h1); `CHK("ro write", 2'h2, r)
		pkt(0, 1, 3, 2); `CHK("plain n", 2, pau_stream_sink_inst.n)
		`CHK("plain w", pk[3], pau_stream_sink_inst.mem[0])
		in_secure_packet_flag <= 1;
		wr(8'h00, 32'h1);
		pkt(0, 0, 3, 2); `CHK("no flag n", 2, pau_stream_sink_inst.n)
		pkt(0, 1, 3, 2); `CHK("tag n", 5, pau_stream_sink_inst.n)
		`CHK("last", 4, pau_stream_sink_inst.lw)
		`CHK("payload", pk[4], pau_stream_sink_inst.mem[4])
		for (int i = 0; i < 3; i++) pk[i] = pau_stream_sink_inst.mem[i];
		for (int k = 0; k < 2; k++) begin
			reverse_link_key[199:160] <= ~reverse_link_key[199:160];
			reverse_link_key_len <= k ? 9'd160 : 9'd200;
			pkt(0, 1, 3, 2);
			for (int i = 0; i < 3; i++) `CHK("trim", pk[i], pau_stream_sink_inst.mem[i])
		end
		wr(8'h00, 32'h0);
		pkt(1, 1, 0, 5); `CHK("rx n", 2, pau_stream_sink_up_inst.n)
		`CHK("rx w", pk[4], pau_stream_sink_up_inst.mem[1])
		`CHK("rx last", 1, pau_stream_sink_up_inst.lw)
		wr(8'h08, 32'h7);
		// first pass corrupts the tag, second restores it and alters the freshness
		for (int k = 0; k < 2; k++) begin
			pk[0] ^= 32'h1;
			if (k == 1) in_freshness_value <= in_freshness_value ^ 96'h1;
			pkt(1, 1, 0, 5); `CHK("bad n", 0, pau_stream_sink_up_inst.n)
		end
		in_freshness_value <= in_freshness_value ^ 96'h1;
		`CHK("fails", 2, fails)
		rd(8'h10); `CHK("fail cnt", 32'h2, d)
		rd(8'h08); `CHK("fail bit", 1'b1, d[0])
		wr(8'h0c, 32'h1);
		repeat (3) @(posedge aclk);
		`CHK("irq on", 1'b1, irq)
		wr(8'h08, 32'h1);
		repeat (3) @(posedge aclk);
		`CHK("irq off", 1'b0, irq)
		wr(8'h00, 32'h1);
		for (int k = 0; k < 2; k++) begin
			reverse_link_key_ok <= k[0];
			reverse_link_key_len <= k ? 9'd159 : 9'd160;
			pkt(0, 1, 3, 2); `CHK("drop n", 0, pau_stream_sink_inst.n)
		end
		rd(8'h08); `CHK("drop bit", 1'b1, d[1])
		wr(8'h00, 32'h100);
		pkt(0, 0, 3, 2); `CHK("all n", 5, pau_stream_sink_inst.n)
		for (int i = 0; i < 3; i++) pk[i] = pau_stream_sink_inst.mem[i];
		wr(8'h00, 32'h101);
		pkt(1, 0, 0, 5); `CHK("term rx", 2, pau_stream_sink_up_inst.n)
		wr(8'h00, 32'h200);
		pkt(0, 0, 3, 2); `CHK("rsvd n", 2, pau_stream_sink_inst.n)
		close_out();
	end
endmodule : pau_auth_unit_bench

`default_nettype wire
